/* File: common/plad_consts.svh */
`ifndef PLAD_CONSTS_SVH
`define PLAD_CONSTS_SVH
`define PLAD_OPCODE 8'hE8
`define PLAD_OP_MSB 15
`define PLAD_OP_LSB 8
`define PLAD_SEL_MSB 7
`define PLAD_SEL_LSB 6
`define PLAD_LIT_MSB 5
`define PLAD_LIT_LSB 0
`define PLAD_SEL_RET 2'h3
`define PLAD_PTR_RST 12'h000
`define PLAD_PC_RST 21'h00_0000
`endif

/* File: common/plad_pkg.sv */
package plad_pkg;
    typedef enum logic [3:0] {
        PLAD_Q1 = 4'h1,
        PLAD_Q2 = 4'h2,
        PLAD_Q3 = 4'h4,
        PLAD_Q4 = 4'h8
    } plad_phase_t;
    typedef logic [11:0] plad_ptr_t;
endpackage : plad_pkg

/* File: src/plad_ptr_file.sv */
`timescale 1ns/1ps
`include "plad_consts.svh"
// Three indirect pointers; read data registered
module plad_ptr_file
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [1:0] wr_sel_in,
    input wire plad_pkg::plad_ptr_t wr_data_in,
    // Read port
    input wire logic [1:0] rd_sel_in,
    output plad_pkg::plad_ptr_t rd_data_out,
    output plad_pkg::plad_ptr_t ptr0_out,
    output plad_pkg::plad_ptr_t ptr1_out,
    output plad_pkg::plad_ptr_t ptr2_out
);
    import plad_pkg::*;
    plad_ptr_t mem_reg [3];
    plad_ptr_t rd_reg;
    // Per-pointer storage
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ptr
            always_ff @(posedge mclk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                    mem_reg[gi] <= `PLAD_PTR_RST;
                else if (wr_en_in && wr_sel_in == 2'(gi))
                    mem_reg[gi] <= wr_data_in;
            end
        end
    endgenerate
    // Registered read; selector 3 is never presented
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rd_reg <= `PLAD_PTR_RST;
        else
            rd_reg <= (rd_sel_in < 2'h3) ? mem_reg[rd_sel_in] : mem_reg[2];
    end
    assign rd_data_out = rd_reg;
    assign ptr0_out = mem_reg[0];
    assign ptr1_out = mem_reg[1];
    assign ptr2_out = mem_reg[2];
endmodule : plad_ptr_file

/* File: src/plad_decode.sv */
`timescale 1ns/1ps
`include "plad_consts.svh"
// Pointer literal add and add-and-return executor
module plad_decode
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Instruction fetch
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    // Return stack and status
    input wire logic [20:0] return_stack_top_in,
    input wire logic [4:0] status_in,
    // Outputs
    output logic busy_out,
    output logic [3:0] phase_out,
    output logic done_out,
    output logic pc_load_out,
    output logic [20:0] pc_out,
    output logic stack_pop_out,
    output logic [4:0] status_out,
    output plad_pkg::plad_ptr_t ptr0_out,
    output plad_pkg::plad_ptr_t ptr1_out,
    output plad_pkg::plad_ptr_t third_indirect_pointer_out
);
    import plad_pkg::*;
    plad_phase_t ph_reg, ph_next;
    logic act_reg, act_next;
    logic ret_reg, ret_next;
    logic nop_reg, nop_next;
    logic [1:0] sel_reg, sel_next;
    logic [5:0] lit_reg, lit_next;
    plad_ptr_t sum_reg, sum_next;
    logic done_reg, done_next;
    logic pcl_reg, pcl_next;
    logic [20:0] pc_reg, pc_next;
    logic [4:0] st_reg;
    logic busy_reg, busy_next;
    logic wr_en;
    logic hit;
    plad_ptr_t rd_data;
    // Recognise the shared opcode byte in the first phase
    assign hit = instr_valid_in &&
        instr_in[`PLAD_OP_MSB:`PLAD_OP_LSB] == `PLAD_OPCODE;
    assign wr_en = act_reg && ph_reg == PLAD_Q4;
    plad_ptr_file u_ptr
    (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .wr_en_in(wr_en),
        .wr_sel_in(sel_reg),
        .wr_data_in(sum_reg),
        .rd_sel_in(sel_reg),
        .rd_data_out(rd_data),
        .ptr0_out(ptr0_out),
        .ptr1_out(ptr1_out),
        .ptr2_out(third_indirect_pointer_out)
    );
    // Phase sequencer and datapath next state
    always_comb
    begin
        ph_next = ph_reg;
        act_next = act_reg;
        ret_next = ret_reg;
        nop_next = nop_reg;
        sel_next = sel_reg;
        lit_next = lit_reg;
        sum_next = sum_reg;
        done_next = 1'b0;
        pcl_next = 1'b0;
        pc_next = pc_reg;
        case (ph_reg)
            PLAD_Q1:
            begin
                // Phases follow the core clock even when the opcode is not
                // ours; stalling here would slip against the fetch path
                ph_next = PLAD_Q2;
                // Decode; an idle nop cycle ignores fetch
                if (nop_reg)
                begin
                    act_next = 1'b0;
                    ph_next = PLAD_Q2;
                end
                else if (hit)
                begin
                    act_next = 1'b1;
                    sel_next = instr_in[`PLAD_SEL_MSB:`PLAD_SEL_LSB];
                    ret_next = (instr_in[`PLAD_SEL_MSB:`PLAD_SEL_LSB]
                        == `PLAD_SEL_RET);
                    if (instr_in[`PLAD_SEL_MSB:`PLAD_SEL_LSB] == `PLAD_SEL_RET)
                        sel_next = 2'h2;
                    ph_next = PLAD_Q2;
                end
            end
            PLAD_Q2:
            begin
                if (act_reg)
                    lit_next = instr_in[`PLAD_LIT_MSB:`PLAD_LIT_LSB];
                ph_next = PLAD_Q3;
            end
            PLAD_Q3:
            begin
                // Unsigned literal zero-extended, wraps at pointer width
                if (act_reg)
                    sum_next = rd_data + {6'h00, lit_reg};
                ph_next = PLAD_Q4;
            end
            PLAD_Q4:
            begin
                ph_next = PLAD_Q1;
                if (act_reg)
                begin
                    act_next = 1'b0;
                    done_next = 1'b1;
                    if (ret_reg)
                    begin
                        pcl_next = 1'b1;
                        pc_next = return_stack_top_in;
                        nop_next = 1'b1;
                        ret_next = 1'b0;
                    end
                end
                else
                    nop_next = 1'b0;
            end
            default:
            begin
                ph_next = PLAD_Q1;
                act_next = 1'b0;
                nop_next = 1'b0;
            end
        endcase
        // Busy while executing or idling through the return's nop cycle
        busy_next = act_next | nop_next;
    end
    // Register all state
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ph_reg <= PLAD_Q1;
            act_reg <= 1'b0;
            ret_reg <= 1'b0;
            nop_reg <= 1'b0;
            sel_reg <= 2'h0;
            lit_reg <= 6'h00;
            sum_reg <= `PLAD_PTR_RST;
            done_reg <= 1'b0;
            pcl_reg <= 1'b0;
            pc_reg <= `PLAD_PC_RST;
            st_reg <= 5'h00;
            busy_reg <= 1'b0;
        end
        else
        begin
            ph_reg <= ph_next;
            act_reg <= act_next;
            ret_reg <= ret_next;
            nop_reg <= nop_next;
            sel_reg <= sel_next;
            lit_reg <= lit_next;
            sum_reg <= sum_next;
            done_reg <= done_next;
            pcl_reg <= pcl_next;
            pc_reg <= pc_next;
            st_reg <= status_in;
            busy_reg <= busy_next;
        end
    end
    assign busy_out = busy_reg;
    assign phase_out = ph_reg;
    assign done_out = done_reg;
    assign pc_load_out = pcl_reg;
    assign pc_out = pc_reg;
    assign stack_pop_out = pcl_reg;
    assign status_out = st_reg;
    // Checks
    AST_SEL3_TO_PTR2: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (ph_reg == PLAD_Q1 && !nop_reg && hit && instr_in[7:6] == 2'h3)
        |=> sel_reg == 2'h2)
        else $error("selector 3 did not target third pointer");
    AST_WRITE_Q4: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !wr_en |=> $stable(ptr0_out) && $stable(ptr1_out)
        && $stable(third_indirect_pointer_out))
        else $error("pointer written outside fourth phase");
    AST_SUM_WRITE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_en && sel_reg == 2'h2) |=> third_indirect_pointer_out
        == $past(sum_reg))
        else $error("sum not written back");
    AST_RET_PC: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_en && ret_reg) |=> pc_load_out && pc_out
        == $past(return_stack_top_in))
        else $error("return did not load stack top");
    AST_NOP_CYCLE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        pc_load_out |-> (!act_reg && nop_reg)[*4])
        else $error("second cycle not idle");
    AST_STATUS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> status_out == $past(status_in))
        else $error("status flags altered");
    AST_LIT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (act_reg && ph_reg == PLAD_Q2) |=> lit_reg
        == $past(instr_in[5:0]))
        else $error("literal not taken");
    AST_ONE_CYCLE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (ph_reg == PLAD_Q1 && !nop_reg && hit) |-> ##3 wr_en ##1 done_out)
        else $error("add not done in one cycle");
    COV_ADD0: cover property (@(posedge mclk_in) wr_en && sel_reg == 2'h0);
    COV_ADD1: cover property (@(posedge mclk_in) wr_en && sel_reg == 2'h1);
    COV_RET: cover property (@(posedge mclk_in) pc_load_out);
endmodule : plad_decode

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    import plad_pkg::*;
    // Stimulus and observed outputs
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [20:0] return_stack_top_in = 21'h00_0000;
    logic [4:0] status_in = 5'h00;
    logic busy_out;
    logic done_out;
    logic pc_load_out;
    logic stack_pop_out;
    logic [3:0] phase_out;
    logic [20:0] pc_out;
    logic [4:0] status_out;
    plad_ptr_t ptr0_out;
    plad_ptr_t ptr1_out;
    plad_ptr_t ptr2_out;
    plad_ptr_t model [3];
    logic [4:0] st_q;
    logic [3:0] ph_q;
    logic hurry = 1'b0;
    int seed = 32'he9c9;
    int fail_count = 0;
    int n_checks = 0;
    int live = 0;

    plad_decode DUT (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in),
        .return_stack_top_in(return_stack_top_in), .status_in(status_in),
        .busy_out(busy_out), .phase_out(phase_out), .done_out(done_out),
        .pc_load_out(pc_load_out), .pc_out(pc_out),
        .stack_pop_out(stack_pop_out), .status_out(status_out),
        .ptr0_out(ptr0_out), .ptr1_out(ptr1_out),
        .third_indirect_pointer_out(ptr2_out)
    );

    // Free running core clock
    initial forever #50 mclk_in = ~mclk_in;

    // Expected acceptance: only the one opcode byte is executed
    function automatic logic accepts(input logic [15:0] w);
        return w[15:8] == 8'he8;
    endfunction : accepts

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // Status passes untouched; phases rotate one-hot every clock
    always @(negedge mclk_in)
    begin
        if (live > 2)
        begin
            chk(21'(status_out), 21'(st_q));
            chk(21'(phase_out), 21'({ph_q[2:0], ph_q[3]}));
        end
        ph_q = phase_out;
        status_in <= 5'($random(seed));
        live = rst_b_in ? live + 1 : 0;
    end
    always @(posedge mclk_in) st_q <= status_in;

    // One fetch in Q1, held through Q2, then result checked at done
    task automatic run_op(input logic [15:0] w, input logic go);
        logic [1:0] s;
        logic ret;
        logic [20:0] top;
        int n;
        s = w[7:6];
        ret = go && (s == 2'h3);
        top = 21'($random(seed));
        while (phase_out !== PLAD_Q1) @(negedge mclk_in);
        instr_in = w;
        instr_valid_in = 1'b1;
        return_stack_top_in = top;
        repeat (2) @(negedge mclk_in);
        instr_valid_in = 1'b0;
        n = 0;
        while (done_out !== 1'b1 && n < 8)
        begin
            @(negedge mclk_in);
            n++;
        end
        chk(21'(done_out), 21'(go));
        if (go)
            model[ret ? 2 : s] += 12'(w[5:0]);
        chk(21'(ptr0_out), 21'(model[0]));
        chk(21'(ptr1_out), 21'(model[1]));
        chk(21'(ptr2_out), 21'(model[2]));
        chk(21'(pc_load_out), 21'(ret));
        chk(21'(stack_pop_out), 21'(ret));
        chk(21'(busy_out), 21'(ret));
        if (ret)
        begin
            chk(pc_out, top);
            if (!hurry)
                repeat (4) @(negedge mclk_in);
        end
    endtask : run_op

    // Main sequence
    initial
    begin
        logic [15:0] w;
        model = '{12'h000, 12'h000, 12'h000};
        repeat (20) @(negedge mclk_in);
        chk(21'(phase_out), 21'(PLAD_Q1));
        chk(21'(ptr2_out), 21'h00_0000);
        chk(21'(done_out), 21'h00_0000);
        chk(pc_out, 21'h00_0000);
        chk(21'(busy_out), 21'h00_0000);
        rst_b_in = 1'b1;
        $display("test reset ended");
        // Largest literal, enough times to wrap the pointer
        repeat (70) run_op(16'he87f, 1'b1);
        run_op(16'he8a3, 1'b1);
        run_op(16'he8c0, 1'b1);
        run_op(16'he8ff, 1'b1);
        $display("test corners ended");
        // Foreign opcodes and a fetch inside the idle cycle are dropped
        run_op(16'he9c5, 1'b0);
        run_op(16'h6845, 1'b0);
        hurry = 1'b1;
        run_op(16'he8c1, 1'b1);
        hurry = 1'b0;
        run_op(16'he805, 1'b0);
        $display("test refusal ended");
        // Random mix, back to back, some with a wrong opcode
        repeat (200)
        begin
            w = {8'he8, 8'($random(seed))};
            if (($random(seed) & 7) == 0)
                w[15:8] = 8'($random(seed));
            run_op(w, accepts(w));
        end
        $display("test random ended");
        complete_run();
    end

    // Watchdog, far beyond the expected run length
    initial
    begin
        #(100 * 20000);
        fail_count++;
        complete_run();
    end
endmodule : tb
